//--- cfg_regs.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module cfg_regs (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    // non-sticky reset (hot reset of the port)
    input  wire logic                      soft_reset_i,
    // port role strap, high on the upstream port
    input  wire logic                      upstream_port_i,
    // next pointer write unlock
    input  wire logic                      cfg_unlock_i,
    // link state in, transmitter control out
    input  wire cfg_regs_pkg::link_state_t link_state_i,
    output cfg_regs_pkg::phy_ctrl_t        phy_ctrl_o,
    // axi4-lite write address
    input  wire logic [11:0]               s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    // axi4-lite write data
    input  wire logic [31:0]               s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]                     s_axi_bresp_o,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    // axi4-lite read address
    input  wire logic [11:0]               s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0]                    s_axi_rdata_o,
    output logic [1:0]                     s_axi_rresp_o,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i
);

    // ========================================
    // reset synchroniser
    logic rst_meta_r;   // first stage, read only by second
    logic rst_sync_r;   // released reset used everywhere
    logic rst_n;

    // release is synchronous, assertion is not
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // ========================================
    // address decode
    // known register index, mapped or not
    function automatic logic is_mapped(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        is_mapped = (idx == cfg_regs_pkg::LINK_CONTROL_TWO_IDX)
                 || (idx == cfg_regs_pkg::LINK_STATUS_TWO_IDX)
                 || (idx == cfg_regs_pkg::SLOT_CAPABILITIES_TWO_IDX)
                 || (idx == cfg_regs_pkg::SLOT_CONTROL_TWO_IDX)
                 || (idx == cfg_regs_pkg::SLOT_STATUS_TWO_IDX)
                 || (idx == cfg_regs_pkg::POWER_MGMT_CAP_HEADER_IDX);
    endfunction

    // ========================================
    // register state
    logic       force_compliance_r;    // sticky
    logic       force_compliance_nxt;
    logic       modified_compl_r;      // sticky
    logic       modified_compl_nxt;
    logic       skip_insert_r;         // sticky
    logic       skip_insert_nxt;
    logic       deemph_select_r;       // sticky
    logic       deemph_select_nxt;
    logic [7:0] next_ptr_r;            // reloaded from the strap by hot reset
    logic [7:0] next_ptr_nxt;
    logic       strap_done_r;          // strap caught once
    logic       strap_done_nxt;

    // ========================================
    // bus state
    logic        aw_held_r;
    logic        aw_held_nxt;
    logic [11:0] aw_addr_r;
    logic [11:0] aw_addr_nxt;
    logic        w_held_r;
    logic        w_held_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0]  w_strb_r;
    logic [3:0]  w_strb_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;

    cfg_regs_pkg::phy_ctrl_t phy_ctrl_r;
    cfg_regs_pkg::phy_ctrl_t phy_ctrl_nxt;

    // ready terms: one write and one read in flight
    assign s_axi_awready_o = !aw_held_r && !bvalid_r;
    assign s_axi_wready_o  = !w_held_r && !bvalid_r;
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign phy_ctrl_o      = phy_ctrl_r;

    // ========================================
    // read value of one register
    logic [31:0] lc2_word;   // link control two, lower fields read 0
    logic [31:0] ls2_word;
    logic [31:0] pm_word;
    always_comb begin
        lc2_word = 32'h0000_0000;
        lc2_word[cfg_regs_pkg::FORCE_COMPLIANCE_BIT] = force_compliance_r;
        lc2_word[cfg_regs_pkg::MODIFIED_COMPL_BIT]   = modified_compl_r;
        lc2_word[cfg_regs_pkg::SKIP_INSERT_BIT]      = skip_insert_r;
        lc2_word[cfg_regs_pkg::DEEMPH_SELECT_BIT]    = deemph_select_r;
        // at 2.5g the bit means nothing, so read zero there
        ls2_word = {31'h0000_0000,
                    link_state_i.rate_5g & link_state_i.cur_deemph_35db};
        // upper header bits lie outside this block and read zero
        pm_word = {12'h000,
                   cfg_regs_pkg::WAKE_CLOCK_REQ,
                   cfg_regs_pkg::PM_SPEC_REVISION,
                   next_ptr_r,
                   cfg_regs_pkg::CAPABILITY_ID_PM
                  };
    end

    // ========================================
    // bus and register next state
    always_comb begin
        aw_held_nxt          = aw_held_r;
        aw_addr_nxt          = aw_addr_r;
        w_held_nxt           = w_held_r;
        w_data_nxt           = w_data_r;
        w_strb_nxt           = w_strb_r;
        bvalid_nxt           = bvalid_r;
        bresp_nxt            = bresp_r;
        rvalid_nxt           = rvalid_r;
        rdata_nxt            = rdata_r;
        rresp_nxt            = rresp_r;
        force_compliance_nxt = force_compliance_r;
        modified_compl_nxt   = modified_compl_r;
        skip_insert_nxt      = skip_insert_r;
        deemph_select_nxt    = deemph_select_r;
        next_ptr_nxt         = next_ptr_r;
        strap_done_nxt       = 1'b1;

        // strap caught on the first cycle after release
        if (!strap_done_r) begin
            next_ptr_nxt = upstream_port_i ? cfg_regs_pkg::NEXT_PTR_UPSTREAM
                                           : cfg_regs_pkg::NEXT_PTR_DOWNSTRM;
        end

        // address and data may arrive in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata_i;
            w_strb_nxt = s_axi_wstrb_i;
        end

        // both halves held: perform the write
        if (aw_held_r && w_held_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = is_mapped(aw_addr_r) ? cfg_regs_pkg::RESP_OKAY
                                               : cfg_regs_pkg::RESP_SLVERR;
            case (aw_addr_r[11:2])
                cfg_regs_pkg::LINK_CONTROL_TWO_IDX: begin
                    // low lane holds the force bit
                    if (w_strb_r[0]) begin
                        force_compliance_nxt =
                            w_data_r[cfg_regs_pkg::FORCE_COMPLIANCE_BIT];
                    end
                    // high lane holds the compliance fields
                    if (w_strb_r[1]) begin
                        modified_compl_nxt =
                            w_data_r[cfg_regs_pkg::MODIFIED_COMPL_BIT];
                        skip_insert_nxt =
                            w_data_r[cfg_regs_pkg::SKIP_INSERT_BIT];
                        deemph_select_nxt =
                            w_data_r[cfg_regs_pkg::DEEMPH_SELECT_BIT];
                    end
                end
                cfg_regs_pkg::POWER_MGMT_CAP_HEADER_IDX: begin
                    // pointer only writable while unlocked
                    if (w_strb_r[1] && cfg_unlock_i) begin
                        next_ptr_nxt = w_data_r[15:8];
                    end
                end
                default: begin
                    // read-only and reserved words drop the write
                end
            endcase
        end

        // response lasts until the master takes it
        if (bvalid_r && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;
        end

        // read: capture value on address handshake
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = is_mapped(s_axi_araddr_i) ? cfg_regs_pkg::RESP_OKAY
                                                   : cfg_regs_pkg::RESP_SLVERR;
            case (s_axi_araddr_i[11:2])
                cfg_regs_pkg::LINK_CONTROL_TWO_IDX:      rdata_nxt = lc2_word;
                cfg_regs_pkg::LINK_STATUS_TWO_IDX:       rdata_nxt = ls2_word;
                cfg_regs_pkg::POWER_MGMT_CAP_HEADER_IDX: rdata_nxt = pm_word;
                // slot words and unmapped reads are all zero
                default:                                 rdata_nxt = 32'h0000_0000;
            endcase
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_nxt = 1'b0;
        end

        // hot reset reloads non-sticky state only
        if (soft_reset_i && strap_done_r) begin
            next_ptr_nxt = upstream_port_i ? cfg_regs_pkg::NEXT_PTR_UPSTREAM
                                           : cfg_regs_pkg::NEXT_PTR_DOWNSTRM;
        end
    end

    // ========================================
    // transmitter control next state
    // registered so the phy sees glitch-free levels
    always_comb begin
        phy_ctrl_nxt = '0;
        // modified pattern only inside polling.compliance
        phy_ctrl_nxt.send_modified =
            modified_compl_r & link_state_i.in_compliance;
        // skp insertion covers both patterns
        phy_ctrl_nxt.insert_skp =
            skip_insert_r & link_state_i.in_compliance;
        // forced entry uses the compliance select
        if (link_state_i.in_compliance && link_state_i.entered_by_force) begin
            phy_ctrl_nxt.tx_deemph_35db = deemph_select_r;
        end else begin
            phy_ctrl_nxt.tx_deemph_35db = link_state_i.sel_deemph_35db;
        end
        // request follows each hot reset while set
        phy_ctrl_nxt.enter_compliance =
            force_compliance_r & link_state_i.hot_reset;
    end

    // ========================================
    // state registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r          <= 1'b0;
            aw_addr_r          <= 12'h000;
            w_held_r           <= 1'b0;
            w_data_r           <= 32'h0000_0000;
            w_strb_r           <= 4'h0;
            bvalid_r           <= 1'b0;
            bresp_r            <= cfg_regs_pkg::RESP_OKAY;
            rvalid_r           <= 1'b0;
            rdata_r            <= 32'h0000_0000;
            rresp_r            <= cfg_regs_pkg::RESP_OKAY;
            // compliance fields default to zero
            force_compliance_r <= 1'b0;
            modified_compl_r   <= 1'b0;
            skip_insert_r      <= 1'b0;
            deemph_select_r    <= 1'b0;
            next_ptr_r         <= cfg_regs_pkg::NEXT_PTR_UPSTREAM;
            strap_done_r       <= 1'b0;
            phy_ctrl_r         <= '0;
        end else begin
            aw_held_r          <= aw_held_nxt;
            aw_addr_r          <= aw_addr_nxt;
            w_held_r           <= w_held_nxt;
            w_data_r           <= w_data_nxt;
            w_strb_r           <= w_strb_nxt;
            bvalid_r           <= bvalid_nxt;
            bresp_r            <= bresp_nxt;
            rvalid_r           <= rvalid_nxt;
            rdata_r            <= rdata_nxt;
            rresp_r            <= rresp_nxt;
            force_compliance_r <= force_compliance_nxt;
            modified_compl_r   <= modified_compl_nxt;
            skip_insert_r      <= skip_insert_nxt;
            deemph_select_r    <= deemph_select_nxt;
            next_ptr_r         <= next_ptr_nxt;
            strap_done_r       <= strap_done_nxt;
            phy_ctrl_r         <= phy_ctrl_nxt;
        end
    end

endmodule

//--- cfg_regs_pkg.sv
// How it works
// - modified-compliance bit sends modified pattern
// - skip bit inserts SKP sets in compliance
// - forced entry: bit 12 picks de-emphasis
// - status bit 0 shows de-emphasis at 5G
// - status bit undefined at 2.5G
// - slot capabilities two reads all zero
// - slot control/status two read zero
// - capability identifier reads 0x1
// - next pointer 0x0 upstream, 0xD0 downstream
// - version field reads 0x3
// - wake clock flag reads zero
// - force-compliance bit plus hot reset enters compliance
package cfg_regs_pkg;
    // ========================================
    // register indices, byte address = 4 * index
    localparam logic [9:0] LINK_CONTROL_TWO_IDX      = 10'h070;
    localparam logic [9:0] LINK_STATUS_TWO_IDX       = 10'h072;
    localparam logic [9:0] SLOT_CAPABILITIES_TWO_IDX = 10'h074;
    localparam logic [9:0] SLOT_CONTROL_TWO_IDX      = 10'h078;
    localparam logic [9:0] SLOT_STATUS_TWO_IDX       = 10'h07A;
    localparam logic [9:0] POWER_MGMT_CAP_HEADER_IDX = 10'h0C0;
    // ========================================
    // link control two field positions
    localparam int FORCE_COMPLIANCE_BIT  = 4;
    localparam int MODIFIED_COMPL_BIT    = 10;
    localparam int SKIP_INSERT_BIT       = 11;
    localparam int DEEMPH_SELECT_BIT     = 12;
    // ========================================
    // power management header constants
    localparam logic [7:0] CAPABILITY_ID_PM   = 8'h01;
    localparam logic [7:0] NEXT_PTR_UPSTREAM  = 8'h00;
    localparam logic [7:0] NEXT_PTR_DOWNSTRM  = 8'hD0;
    localparam logic [2:0] PM_SPEC_REVISION   = 3'h3;
    localparam logic       WAKE_CLOCK_REQ     = 1'h0;
    // ========================================
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ========================================
    // link state seen from the training logic
    typedef struct packed {
        logic in_compliance;     // ltssm in polling.compliance
        logic entered_by_force;  // entry came from forced compliance
        logic hot_reset;         // hot reset seen on the link
        logic rate_5g;           // link running at 5.0 gbps
        logic cur_deemph_35db;   // de-emphasis in use, 1 = -3.5 db
        logic sel_deemph_35db;   // normal selectable de-emphasis
    } link_state_t;
    // controls toward the transmitter
    typedef struct packed {
        logic send_modified;     // modified compliance pattern
        logic insert_skp;        // periodic skp ordered sets
        logic tx_deemph_35db;    // transmit de-emphasis, 1 = -3.5 db
        logic enter_compliance;  // request held while hot reset is seen
    } phy_ctrl_t;
endpackage

//--- cfg_regs_sva.sv
`timescale 1ns/10ps
// ========================================
// port checker for the register bank
module cfg_regs_sva (
    // clock and reset
    input wire logic                      core_clk_i,
    input wire logic                      resetn_i,
    // link side
    input wire cfg_regs_pkg::link_state_t link_state_i,
    input wire cfg_regs_pkg::phy_ctrl_t   phy_ctrl_o,
    // read channels
    input wire logic [11:0]               s_axi_araddr_i,
    input wire logic                      s_axi_arvalid_i,
    input wire logic                      s_axi_arready_o,
    input wire logic [31:0]               s_axi_rdata_o,
    input wire logic                      s_axi_rvalid_o,
    input wire logic                      s_axi_rready_i
);
    localparam logic [11:0] A_STS  = {cfg_regs_pkg::LINK_STATUS_TWO_IDX, 2'b00};
    localparam logic [11:0] A_SCAP = {cfg_regs_pkg::SLOT_CAPABILITIES_TWO_IDX, 2'b00};
    localparam logic [11:0] A_SCTL = {cfg_regs_pkg::SLOT_CONTROL_TWO_IDX, 2'b00};
    localparam logic [11:0] A_PM   = {cfg_regs_pkg::POWER_MGMT_CAP_HEADER_IDX, 2'b00};
    // edges since reset release; the internal copy lags by two
    logic [1:0] up_cnt_r;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up_cnt_r <= 2'h0;
        end else if (up_cnt_r != 2'h3) begin
            up_cnt_r <= up_cnt_r + 2'h1;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (up_cnt_r != 2'h3);
    // a read address taken at a given place
    sequence rd_req(a);
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
    endsequence
    a_modified_gated: assert property (phy_ctrl_o.send_modified
        |-> $past(link_state_i.in_compliance))
        else $error("modified pattern outside compliance");
    a_skip_gated: assert property (phy_ctrl_o.insert_skp
        |-> $past(link_state_i.in_compliance))
        else $error("skip insertion outside compliance");
    a_deemph_normal: assert property (
        !$past(link_state_i.in_compliance && link_state_i.entered_by_force)
        |-> phy_ctrl_o.tx_deemph_35db == $past(link_state_i.sel_deemph_35db))
        else $error("de-emphasis not from selection");
    a_enter_on_hot: assert property (phy_ctrl_o.enter_compliance
        |-> $past(link_state_i.hot_reset))
        else $error("compliance entry without hot reset");
    a_status_at_5g: assert property (rd_req(A_STS) ##0 link_state_i.rate_5g
        |=> s_axi_rvalid_o && s_axi_rdata_o[15:1] == 15'h0
        && s_axi_rdata_o[0] == $past(link_state_i.cur_deemph_35db))
        else $error("status bit wrong");
    a_slot_cap_zero: assert property (rd_req(A_SCAP)
        |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h0)
        else $error("slot capabilities not zero");
    a_slot_ctl_zero: assert property (rd_req(A_SCTL) or rd_req(A_SCTL + 12'h008)
        |=> s_axi_rdata_o == 32'h0)
        else $error("slot control or status not zero");
    a_pm_fixed: assert property (rd_req(A_PM)
        |=> s_axi_rdata_o[7:0] == cfg_regs_pkg::CAPABILITY_ID_PM
        && s_axi_rdata_o[19:16] == {cfg_regs_pkg::WAKE_CLOCK_REQ,
                                    cfg_regs_pkg::PM_SPEC_REVISION})
        else $error("pm header fixed fields wrong");
    a_read_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while answer pending");
endmodule
bind cfg_regs cfg_regs_sva u_cfg_regs_sva (.*);

//--- link_partner_model.sv
`timescale 1ns/10ps
// ========================================
// link partner: training state as seen by the port
module link_partner_model (
    // clock and scenario select
    input  wire logic                 core_clk_i,
    input  wire logic [2:0]           mode_i,
    // link state toward the port
    output cfg_regs_pkg::link_state_t link_state_o
);
    logic flip_r = 1'b0;  // toggles so an undefined bit never looks steady
    always @(posedge core_clk_i) begin
        flip_r <= ~flip_r;
        case (mode_i)
            3'h1: link_state_o <= 6'b110000;  // forced compliance, sel -6 db
            3'h2: link_state_o <= 6'b100001;  // plain compliance, sel -3.5 db
            3'h3: link_state_o <= 6'b001000;  // hot reset on the link
            3'h4: link_state_o <= 6'b000111;  // 5g, -3.5 db selected and in use
            3'h5: link_state_o <= 6'b000100;  // 5g, -6 db in use
            default: link_state_o <= {4'h0, flip_r, 1'b0};  // 2.5g, level meaningless
        endcase
    end
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ========================================
    // stimulus signals
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic soft_reset_i = 1'b0;
    logic upstream_port_i = 1'b1;
    logic cfg_unlock_i = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    cfg_regs_pkg::link_state_t link_state;
    cfg_regs_pkg::phy_ctrl_t phy_ctrl;
    int n_errors = 0;
    int checks_done = 0;
    localparam logic [11:0] A_CTL  = {cfg_regs_pkg::LINK_CONTROL_TWO_IDX, 2'b00};
    localparam logic [11:0] A_STS  = {cfg_regs_pkg::LINK_STATUS_TWO_IDX, 2'b00};
    localparam logic [11:0] A_SCAP = {cfg_regs_pkg::SLOT_CAPABILITIES_TWO_IDX, 2'b00};
    localparam logic [11:0] A_SCTL = {cfg_regs_pkg::SLOT_CONTROL_TWO_IDX, 2'b00};
    localparam logic [11:0] A_SSTS = {cfg_regs_pkg::SLOT_STATUS_TWO_IDX, 2'b00};
    localparam logic [11:0] A_PM   = {cfg_regs_pkg::POWER_MGMT_CAP_HEADER_IDX, 2'b00};
    localparam logic [1:0]  OK = cfg_regs_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR = cfg_regs_pkg::RESP_SLVERR;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} row_t;
    // plain reads: address, expected data, expected response
    row_t rows [6] = '{'{A_SCAP, 32'h0, OK}, '{A_SCTL, 32'h0, OK}, '{A_SSTS, 32'h0, OK},
        '{A_PM, 32'h00030001, OK}, '{A_CTL, 32'h0, OK}, '{12'h004, 32'h0, ERR}};
    always #12.5 core_clk_i = ~core_clk_i;
    // ========================================
    // design and far side
    cfg_regs u_cfg_regs (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .soft_reset_i(soft_reset_i), .upstream_port_i(upstream_port_i),
        .cfg_unlock_i(cfg_unlock_i), .link_state_i(link_state), .phy_ctrl_o(phy_ctrl),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    link_partner_model u_link_partner_model (.core_clk_i(core_clk_i), .mode_i(mode),
        .link_state_o(link_state));
    // ========================================
    // checking and closing
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a wait that ran out ends the run as a mismatch
    task automatic timed_out;
        n_errors++;
        $display("wrong value handshake expected done seen timeout");
        final_report();
    endtask
    // ========================================
    // bus master: each channel released at its own handshake edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                          input logic [3:0] s = 4'hF);
        logic aw_go, w_go, b_go;
        b_go = 1'b0;
        @(posedge core_clk_i);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 40 && !b_go; n++) begin
            @(negedge core_clk_i);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid && bready;
            if (b_go) chk_val("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge core_clk_i);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            if (b_go) bready <= 1'b0;
        end
        if (!b_go) timed_out();
    endtask
    // lag holds rready low for that many cycles so the answer must wait
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                          input int lag = 0);
        logic ar_go, r_go;
        r_go = 1'b0;
        @(posedge core_clk_i);
        araddr <= a;
        {arvalid, rready} <= {1'b1, lag == 0};
        for (int n = 0; n < 40 && !r_go; n++) begin
            @(negedge core_clk_i);
            ar_go = arvalid && arready;
            r_go = rvalid && rready;
            if (r_go) chk_val("rdata", e, rdata);
            if (r_go) chk_val("rresp", {30'h0, er}, {30'h0, rresp});
            @(posedge core_clk_i);
            if (ar_go) arvalid <= 1'b0;
            if (r_go) rready <= 1'b0;
            if (n + 1 == lag) rready <= 1'b1;
        end
        if (!r_go) timed_out();
    endtask
    // new link state, then transmitter controls checked three cycles later
    task automatic phy_exp(input logic [2:0] m, input logic [3:0] e);
        @(posedge core_clk_i);
        mode <= m;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk_val("phy_ctrl", {28'h0, e}, {28'h0, phy_ctrl});
    endtask
    task automatic do_reset;
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
    endtask
    // ========================================
    // main sequence
    initial begin
        do_reset();
        foreach (rows[i]) rd_chk(rows[i].a, rows[i].d, rows[i].r);
        $display("test reset values done");
        foreach (rows[i]) axi_wr(rows[i].a, 32'hFFFFFFFF, rows[i].r);
        rd_chk(A_PM, 32'h00030001, OK);
        foreach (rows[i]) if (i < 3) rd_chk(rows[i].a, 32'h0, OK);
        $display("test reserved writes done");
        axi_wr(A_CTL, 32'h00001C10, OK);
        rd_chk(A_CTL, 32'h00001C10, OK);
        phy_exp(3'h1, 4'hE);
        axi_wr(A_CTL, 32'h00000C10, OK);
        phy_exp(3'h1, 4'hC);
        phy_exp(3'h2, 4'hE);
        phy_exp(3'h3, 4'h1);
        $display("test compliance controls done");
        phy_exp(3'h4, 4'h2);
        rd_chk(A_STS, 32'h1, OK);
        phy_exp(3'h5, 4'h0);
        rd_chk(A_STS, 32'h0, OK);
        $display("test status done");
        upstream_port_i <= 1'b0;
        @(posedge core_clk_i);
        soft_reset_i <= 1'b1;
        @(posedge core_clk_i);
        soft_reset_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rd_chk(A_PM, 32'h0003D001, OK, 3);
        rd_chk(A_CTL, 32'h00000C10, OK);
        cfg_unlock_i <= 1'b1;
        axi_wr(A_PM, 32'hFFFFFFFF, OK);
        rd_chk(A_PM, 32'h0003FF01, OK);
        cfg_unlock_i <= 1'b0;
        // low lane only: force bit cleared, compliance fields kept
        axi_wr(A_CTL, 32'h0, OK, 4'h1);
        rd_chk(A_CTL, 32'h00000C00, OK);
        $display("test pointer and soft reset done");
        do_reset();
        rd_chk(A_CTL, 32'h0, OK);
        axi_wr(A_CTL, 32'h0, OK);
        $display("test power reset done");
        final_report();
    end
endmodule
